// [mldo_pkg.sv]
package mldo_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0]  REG_OVERRIDE_OFS   = 8'hEE;
	localparam logic [7:0]  REG_STATUS_OFS     = 8'hF8;
	localparam logic [31:0] REG_OVERRIDE_RST   = 32'h00000000;
	localparam logic [31:0] UNMAPPED_RDATA     = 32'h00000000;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int BYPASS_BIT    = 26;
	localparam int VD_LSB        = 16;
	localparam int VQ_LSB        = 6;
	localparam int CODE_W        = 10;
	localparam int GO_BIT        = 5;
	localparam int RES_BIT       = 4;
	localparam int IND_BIT       = 3;
	localparam int KE_BIT        = 2;
	localparam int MECH_BIT      = 1;
	localparam int SHADOW_BIT    = 0;
	localparam int USED_MSB      = 26;

	// ************************************************************
	// Code mapping
	// ************************************************************
	localparam logic [9:0]  CODE_POS_LIMIT = 10'h1F4;
	localparam logic [9:0]  CODE_NEG_START = 10'h200;
	localparam logic [10:0] CODE_WRAP      = 11'h400;

	// Measurement step length, in clock cycles
	localparam int STEP_CYCLES = 16;

	typedef struct packed {
		logic       bypass;
		logic [9:0] vd_code;
		logic [9:0] vq_code;
		logic       go;
		logic       res_en;
		logic       ind_en;
		logic       ke_en;
		logic       mech_en;
		logic       shadow_en;
	} mldo_ctrl_s;

	typedef struct packed {
		logic              valid;
		logic signed [10:0] num;
	} mldo_ref_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RES,
		ST_IND,
		ST_KE,
		ST_MECH,
		ST_SHADOW
	} mldo_meas_e;

endpackage

// [mldo_measure.sv]
`timescale 1ns/1ps
// Parameter measurement sequencer: runs each enabled step for a fixed time.
module mldo_measure #(
	parameter int STEP = mldo_pkg::STEP_CYCLES
) (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst_n,
	input  wire logic                 i_ce,
	input  wire logic                 i_start,
	input  wire mldo_pkg::mldo_ctrl_s i_ctrl,
	output logic                      o_busy,
	output logic                      o_shadow_copy,
	output mldo_pkg::mldo_meas_e      o_state
);
	mldo_pkg::mldo_meas_e state_r, state_nxt;
	logic [15:0]          cnt_r, cnt_nxt;
	logic [4:0]           en_r, en_nxt;
	logic                 copy_r, copy_nxt;

	// Next enabled step after the given one, skipping disabled measurements
	function automatic mldo_pkg::mldo_meas_e next_step(input mldo_pkg::mldo_meas_e cur,
			input logic [4:0] en);
		mldo_pkg::mldo_meas_e n;
		n = mldo_pkg::ST_IDLE;
		if (cur == mldo_pkg::ST_IDLE && en[4])
			n = mldo_pkg::ST_RES;
		else if (cur inside {mldo_pkg::ST_IDLE, mldo_pkg::ST_RES} && en[3])
			n = mldo_pkg::ST_IND;
		else if (cur inside {mldo_pkg::ST_IDLE, mldo_pkg::ST_RES, mldo_pkg::ST_IND} && en[2])
			n = mldo_pkg::ST_KE;
		else if (cur != mldo_pkg::ST_MECH && cur != mldo_pkg::ST_SHADOW && en[1])
			n = mldo_pkg::ST_MECH;
		else if (cur != mldo_pkg::ST_SHADOW && en[0])
			n = mldo_pkg::ST_SHADOW;
		return n;
	endfunction

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		en_nxt    = en_r;
		copy_nxt  = 1'b0;
		case (state_r)
			mldo_pkg::ST_IDLE: begin
				if (i_start) begin
					en_nxt    = {i_ctrl.res_en, i_ctrl.ind_en, i_ctrl.ke_en, i_ctrl.mech_en,
						i_ctrl.shadow_en};
					state_nxt = next_step(mldo_pkg::ST_IDLE, en_nxt); // R6 R7 R8
					cnt_nxt   = 16'h0000;
				end
			end
			mldo_pkg::ST_SHADOW: begin
				copy_nxt  = 1'b1; // R9
				state_nxt = mldo_pkg::ST_IDLE;
			end
			default: begin
				if (cnt_r == 16'(STEP - 1)) begin
					cnt_nxt   = 16'h0000;
					state_nxt = next_step(state_r, en_r); // R7 R8
				end else begin
					cnt_nxt = cnt_r + 16'h0001;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= mldo_pkg::ST_IDLE;
			cnt_r   <= 16'h0000;
			en_r    <= 5'h00;
			copy_r  <= 1'b0;
		end else if (i_ce) begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			en_r    <= en_nxt;
			copy_r  <= copy_nxt;
		end
	end

	assign o_busy        = (state_r != mldo_pkg::ST_IDLE);
	assign o_shadow_copy = copy_r;
	assign o_state       = state_r;

	skip_res_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R7
		(state_r == mldo_pkg::ST_IDLE && i_ce && i_start && !i_ctrl.res_en)
		|=> state_r != mldo_pkg::ST_RES) else $error("resistance step ran while disabled");
	skip_other_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R8
		(state_r == mldo_pkg::ST_IND) |-> en_r[3]) else $error("inductance step ran while disabled");
	shadow_copy_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R9
		(i_ce && state_r == mldo_pkg::ST_SHADOW) |=> copy_r) else $error("shadow copy missing");
	cov_full_c: cover property (@(posedge i_clk) state_r == mldo_pkg::ST_MECH ##[1:100] copy_r);

endmodule // mldo_measure

// [mldo_regs.sv]
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
// ************************************************************
// Loop debug override register with measurement launcher
// ************************************************************
// Contract
// R1: Override register sits at 0xEE and resets to all zeros.
// R2: Bypass bit high disables current and speed loops; low runs normally.
// R3: d-axis reference is code/500 below 500, (code-1024)/500 above 512.
// R4: q-axis reference uses the same mapping on the q-axis code.
// R5: Software writes only codes 0..500 or 512..1000 into voltage fields.
// R6: Writing 1 to the go bit starts the measurement routine.
// R7: Resistance measurement runs only when its enable bit is set.
// R8: Inductance, back-EMF and mechanical measurements each need their enable.
// R9: Copy enable set copies measured parameters into shadow registers.
// R10: Bits 31..27 read zero, 26 bypass, 25..16 d, 15..6 q, 5..0 controls.
module mldo_regs #(
	parameter int STEP = mldo_pkg::STEP_CYCLES
) (
	input  wire logic         I_CLOCK,
	input  wire logic         I_RST_N,
	input  wire logic         I_CE,
	input  wire logic [7:0]   I_ADDRESS,
	input  wire logic         I_READ,
	input  wire logic         I_WRITE,
	input  wire logic [3:0]   I_BYTEENABLE,
	input  wire logic [31:0]  I_WRITEDATA,
	output logic [31:0]       O_READDATA,
	output logic              O_WAITREQUEST,
	output logic              O_LOOP_BYPASS,
	output logic              O_D_REF_VALID,
	output logic signed [10:0] O_D_REF_NUM,
	output logic              O_Q_REF_VALID,
	output logic signed [10:0] O_Q_REF_NUM,
	output logic              O_MEASURE_BUSY,
	output logic              O_SHADOW_COPY
);
	// ************************************************************
	// Register storage and bus slave
	// ************************************************************
	logic [31:0]          reg_r, reg_nxt;
	logic [31:0]          rdata_r, rdata_nxt;
	logic                 ack_r, ack_nxt;
	logic                 go_r, go_nxt;
	logic                 busy_r, shcopy_r;
	mldo_pkg::mldo_ref_s  d_r, d_nxt, q_r, q_nxt;
	mldo_pkg::mldo_ctrl_s ctrl;
	logic                 meas_busy, meas_copy;
	mldo_pkg::mldo_meas_e meas_state;
	logic [31:0]          bmask;
	logic                 req;

	// Map a 10-bit code to its reference numerator over 500; codes in 500..512 are invalid
	function automatic mldo_pkg::mldo_ref_s map_code(input logic [9:0] c);
		mldo_pkg::mldo_ref_s r;
		r.valid = 1'b0;
		r.num   = 11'sh000;
		if (c < mldo_pkg::CODE_POS_LIMIT) begin
			r.valid = 1'b1;
			r.num   = signed'({1'b0, c});
		end else if (c > mldo_pkg::CODE_NEG_START) begin
			r.valid = 1'b1;
			r.num   = signed'(11'({1'b0, c} - mldo_pkg::CODE_WRAP));
		end
		return r;
	endfunction

	assign ctrl  = mldo_pkg::mldo_ctrl_s'(reg_r[mldo_pkg::USED_MSB:0]);
	assign req   = (I_READ || I_WRITE) && !ack_r;
	assign bmask = {{8{I_BYTEENABLE[3]}}, {8{I_BYTEENABLE[2]}}, {8{I_BYTEENABLE[1]}}, {8{I_BYTEENABLE[0]}}};

	always_comb begin
		reg_nxt   = reg_r;
		rdata_nxt = rdata_r;
		ack_nxt   = 1'b0;
		go_nxt    = 1'b0;
		if (req) begin
			ack_nxt = 1'b1;
			if (I_WRITE && I_ADDRESS == mldo_pkg::REG_OVERRIDE_OFS) begin
				reg_nxt = ((reg_r & ~bmask) | (I_WRITEDATA & bmask)) & 32'h07FFFFFF; // R10
				go_nxt  = I_BYTEENABLE[0] && I_WRITEDATA[mldo_pkg::GO_BIT]; // R6
			end
			if (I_READ) begin
				case (I_ADDRESS)
					mldo_pkg::REG_OVERRIDE_OFS: rdata_nxt = reg_r & 32'h07FFFFFF; // R10
					mldo_pkg::REG_STATUS_OFS:   rdata_nxt = {29'h0, 3'(meas_state)};
					default:                    rdata_nxt = mldo_pkg::UNMAPPED_RDATA;
				endcase
			end
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			reg_r   <= mldo_pkg::REG_OVERRIDE_RST; // R1
			rdata_r <= 32'h00000000;
			ack_r   <= 1'b0;
			go_r    <= 1'b0;
		end else if (I_CE) begin
			reg_r   <= reg_nxt;
			rdata_r <= rdata_nxt;
			ack_r   <= ack_nxt;
			go_r    <= go_nxt;
		end
	end

	// ************************************************************
	// Forced voltage references
	// ************************************************************
	// Outside bypass the references read as not valid, so the loops own Vd/Vq
	always_comb begin
		d_nxt = '0;
		q_nxt = '0;
		if (ctrl.bypass) begin
			d_nxt = map_code(ctrl.vd_code); // R2 R3
			q_nxt = map_code(ctrl.vq_code); // R2 R4
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			d_r      <= '0;
			q_r      <= '0;
			busy_r   <= 1'b0;
			shcopy_r <= 1'b0;
		end else if (I_CE) begin
			d_r      <= d_nxt;
			q_r      <= q_nxt;
			busy_r   <= meas_busy;
			shcopy_r <= meas_copy;
		end
	end

	// ************************************************************
	// Measurement sequencer
	// ************************************************************
	mldo_measure #(
		.STEP (STEP)
	) u_measure (
		.i_clk         (I_CLOCK),
		.i_rst_n       (I_RST_N),
		.i_ce          (I_CE),
		.i_start       (go_r),
		.i_ctrl        (ctrl),
		.o_busy        (meas_busy),
		.o_shadow_copy (meas_copy),
		.o_state       (meas_state)
	);

	assign O_READDATA     = rdata_r;
	// Answer one cycle after the request; held high until then
	assign O_WAITREQUEST  = !ack_r;
	assign O_LOOP_BYPASS  = reg_r[mldo_pkg::BYPASS_BIT]; // R2
	assign O_D_REF_VALID  = d_r.valid;
	assign O_D_REF_NUM    = d_r.num;
	assign O_Q_REF_VALID  = q_r.valid;
	assign O_Q_REF_NUM    = q_r.num;
	assign O_MEASURE_BUSY = busy_r;
	assign O_SHADOW_COPY  = shcopy_r;

	// ************************************************************
	// Checks
	// ************************************************************
	reset_zero_a: assert property (@(posedge I_CLOCK) $rose(I_RST_N) |-> reg_r == 32'h00000000) // R1
		else $error("register not zero after reset");
	resv_zero_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R10
		reg_r[31:27] == 5'h00) else $error("reserved bits set");
	bypass_off_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R2
		(I_CE && !ctrl.bypass) |=> !d_r.valid && !q_r.valid) else $error("reference forced without bypass");
	d_neg_map_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R3
		(I_CE && ctrl.bypass && ctrl.vd_code > 10'h200)
		|=> d_r.valid && d_r.num == signed'(11'({1'b0, $past(ctrl.vd_code)} - 11'h400)))
		else $error("d-axis negative mapping wrong");
	q_pos_map_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R4
		(I_CE && ctrl.bypass && ctrl.vq_code < 10'h1F4)
		|=> q_r.valid && q_r.num == signed'({1'b0, $past(ctrl.vq_code)}))
		else $error("q-axis positive mapping wrong");
	go_start_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // R6
		(I_CE && go_r && meas_state == mldo_pkg::ST_IDLE && (ctrl.res_en || ctrl.mech_en))
		|=> meas_busy) else $error("measurement did not start");
	wait_ack_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
		(I_CE && req) |=> !O_WAITREQUEST) else $error("bus answer late");
	cov_bypass_c: cover property (@(posedge I_CLOCK) d_r.valid && d_r.num < 0);
	cov_go_c: cover property (@(posedge I_CLOCK) go_r ##1 meas_busy);
	cov_write_c: cover property (@(posedge I_CLOCK) req && I_WRITE);

endmodule // mldo_regs

// [mldo_regs_tb.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module mldo_regs_tb;
	localparam int STEP = 4;
	logic               clk = 1'b0;
	logic               rst_n = 1'b0;
	logic               ce = 1'b1;
	logic [7:0]         addr = 8'h00;
	logic               rd_s = 1'b0;
	logic               wr_s = 1'b0;
	logic [3:0]         be = 4'h0;
	logic [31:0]        wdata = 32'h00000000;
	logic [31:0]        rdata;
	logic               waitreq;
	logic               bypass;
	logic               d_valid;
	logic               q_valid;
	logic signed [10:0] d_num;
	logic signed [10:0] q_num;
	logic               busy;
	logic               shadow;
	int                 err_count = 0;
	int                 tests_run = 0;
	int                 pulses = 0;
	logic [31:0]        seed = 32'h00000002;
	logic [31:0]        mdl = 32'h00000000;
	logic [31:0]        rv;
	logic [5:0]         seen;
	int                 w;

	mldo_regs #(.STEP(STEP)) i_mldo_regs (.I_CLOCK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_ADDRESS(addr),
		.I_READ(rd_s), .I_WRITE(wr_s), .I_BYTEENABLE(be), .I_WRITEDATA(wdata), .O_READDATA(rdata),
		.O_WAITREQUEST(waitreq), .O_LOOP_BYPASS(bypass), .O_D_REF_VALID(d_valid), .O_D_REF_NUM(d_num),
		.O_Q_REF_VALID(q_valid), .O_Q_REF_NUM(q_num), .O_MEASURE_BUSY(busy), .O_SHADOW_COPY(shadow));

	always #25 clk = ~clk;
	// Sampled mid-cycle so the registered pulse is settled
	always @(negedge clk) if (shadow === 1'b1) pulses++;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic signed [10:0] exp_num(input logic [9:0] c, input logic b);
		if (b && c < 10'h1F4) return $signed({1'b0, c});
		if (b && c > 10'h200) return $signed({1'b0, c} - 11'h400);
		return 11'sh000;
	endfunction

	task automatic bus(input logic w_n, input logic [7:0] a, input logic [31:0] d, input logic [3:0] m);
		int n;
		n = 0;
		@(posedge clk);
		wr_s <= w_n;
		rd_s <= !w_n;
		addr <= a;
		wdata <= d;
		be <= m;
		// Waitrequest is judged on the rising edge, where the slave sees the request too
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		if (n >= 50) begin
			err_count++;
			$display("[ERR] %0t no bus answer", $time);
		end
		rv = rdata;
		wr_s <= 1'b0;
		rd_s <= 1'b0;
	endtask

	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		mdl = 32'h00000000;
	endtask

	task automatic set_ref(input logic b, input logic [9:0] vd, input logic [9:0] vq);
		bus(1'b1, 8'hEE, {5'h00, b, vd, vq, 6'h00}, 4'hF);
		repeat (3) @(negedge clk);
		`CHK(bypass, b)
		`CHK(d_valid, b && (vd < 10'h1F4 || vd > 10'h200))
		`CHK(d_num, exp_num(vd, b))
		`CHK(q_valid, b && (vq < 10'h1F4 || vq > 10'h200))
		`CHK(q_num, exp_num(vq, b))
	endtask

	task automatic print_verdict();
		if (err_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		#2000000;
		err_count++;
		print_verdict();
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin : main
		logic [9:0] codes [8];
		logic [31:0] d;
		logic [31:0] m;
		logic [9:0] c1;
		logic [9:0] c2;
		codes = '{10'h000, 10'h001, 10'h1F3, 10'h1F4, 10'h1F9, 10'h200, 10'h201, 10'h3E8};
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		`CHK({bypass, d_valid, q_valid, busy, shadow, waitreq}, 6'h01)
		bus(1'b0, 8'hEE, 32'h00000000, 4'hF);
		`CHK(rv, 32'h00000000)
		for (int i = 0; i < 40; i++) begin
			d = rnd() & ~32'h00000020;
			m = {{8{d[3]}}, {8{d[2]}}, {8{d[1]}}, {8{d[0]}}} | 32'h000000FF;
			bus(1'b1, 8'hEE, rnd() & ~32'h00000020, m[3:0] == 4'h0 ? 4'h1 : {d[3:1], 1'b1});
			mdl = (mdl & ~{{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}}) | (wdata & {{8{be[3]}},
				{8{be[2]}}, {8{be[1]}}, {8{be[0]}}});
			bus(1'b0, 8'hEE, 32'h00000000, 4'hF);
			`CHK(rv, mdl & 32'h07FFFFFF)
		end
		bus(1'b1, 8'hEC, 32'hFFFFFFFF, 4'hF);
		bus(1'b1, 8'hF8, 32'hFFFFFFFF, 4'hF);
		bus(1'b0, 8'hEC, 32'h00000000, 4'hF);
		`CHK(rv, mldo_pkg::UNMAPPED_RDATA)
		bus(1'b0, 8'hEE, 32'h00000000, 4'hF);
		`CHK(rv, mdl & 32'h07FFFFFF)
		do_reset();
		bus(1'b0, 8'hEE, 32'h00000000, 4'hF);
		`CHK(rv, 32'h00000000)
		for (int i = 0; i < 8; i++) set_ref(i[0] | i[2], codes[i], codes[7 - i]);
		for (int i = 0; i < 16; i++) begin
			c1 = 10'(rnd() % 32'd1001);
			c2 = 10'(rnd() % 32'd1001);
			// Keep codes inside the software range
			if (c1 > 10'h1F4 && c1 < 10'h200) c1 = 10'h200;
			if (c2 > 10'h1F4 && c2 < 10'h200) c2 = 10'h200;
			set_ref(rnd() % 4 != 0, c1, c2);
		end
		for (int en = 0; en < 32; en++) begin
			pulses = 0;
			seen = 6'h00;
			bus(1'b1, 8'hEE, 32'h00000020 | en, 4'h1);
			repeat (20) begin
				bus(1'b0, 8'hF8, 32'h00000000, 4'hF);
				seen[rv[2:0]] = 1'b1;
			end
			w = 0;
			while (busy !== 1'b0 && w < 200) begin
				@(negedge clk);
				w++;
			end
			`CHK(busy, 1'b0)
			`CHK(seen[1], en[4])
			`CHK(seen[4:2], {en[1], en[2], en[3]})
			`CHK(pulses, en[0] ? 1 : 0)
		end
		// Clock enable low must hold a running measurement where it stands
		bus(1'b1, 8'hEE, 32'h00000030, 4'h1);
		@(posedge clk);
		ce <= 1'b0;
		repeat (20) @(negedge clk);
		`CHK(busy, 1'b1)
		@(posedge clk);
		ce <= 1'b1;
		repeat (10) @(negedge clk);
		`CHK(busy, 1'b0)
		print_verdict();
	end
endmodule // mldo_regs_tb
